// ==== hdl/mac_accumulate_datapath.sv ====
`timescale 1ns/10ps
// How it works
// - Extension flag marks significant bits above bit 31
// - A input: zero, round, product or concatenation
// - B input: accumulator, shifted/inverted, or zero
// - Saturation loads most positive or negative value
// - Saturation sets sticky limit flag
// - Forty-bit overflow sets sticky overflow flag
// - Accumulator is high, low and extension parts
// - Limited view clamps only when extension set
// - Limited read leaves accumulator and flags alone
// - Shifter: none, left or right up to eight
// - Left shifts update flags and saturate
// - Thirteen-bit count or five-bit immediate
// - Count N gives N+1 executions
// - Repeat active flag held until last execution
// - Immediate count loads value minus one; zero loads zero
// - Interrupted repeat holds flag and count
// - Masked rising flags raise coprocessor interrupt
// - Class B trap number Ah, trap bit six
// - Interrupt answered within three instruction cycles
// - Rounding adds at bit 15, clears low word
// - Fraction select shifts product left one
module mac_accumulate_datapath
    import mac_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_op_valid,
    input wire a_sel_e i_a_sel,
    input wire logic i_concat_shift,
    input wire b_sel_e i_b_sel,
    input wire shift_e i_shift_mode,
    input wire logic [SH_AMT_W-1:0] i_shift_amt,
    input wire logic i_round,
    input wire logic i_ma_signed,
    input wire logic i_mb_signed,
    input wire logic [WORD_W-1:0] i_ma,
    input wire logic [WORD_W-1:0] i_mb,
    input wire logic [WORD_W-1:0] i_wdata,
    input wire logic i_msw_wr,
    input wire logic i_mcw_wr,
    input wire logic i_mrw_wr,
    input wire logic i_mah_wr,
    input wire logic i_mal_wr,
    input wire logic i_rep_start,
    input wire logic i_rep_imm_valid,
    input wire logic [REP_IMM_W-1:0] i_rep_imm,
    input wire logic i_rep_exec,
    input wire logic i_trap_flag_clr,
    output logic o_rep_again,
    output logic [WORD_W-1:0] o_mac_status_word,
    output logic [WORD_W-1:0] o_mac_control_word,
    output logic [WORD_W-1:0] o_mac_repeat_word,
    output logic [WORD_W-1:0] o_acc_high_word,
    output logic [WORD_W-1:0] o_acc_low_word,
    output logic [WORD_W-1:0] o_limited_acc_view,
    output logic o_coproc_irq,
    output logic o_coproc_trap_flag,
    output logic [3:0] o_trap_number
);

    logic [ACC_W-1:0] acc_q;
    logic [ACC_W-1:0] acc_d;
    logic [FLG_W-1:0] flg_q;
    logic [FLG_W-1:0] flg_d;
    logic [WORD_W-1:0] mcw_q;
    logic [WORD_W-1:0] mcw_d;
    logic [WORD_W-1:0] lim_q;
    logic [WORD_W-1:0] lim_d;
    logic irq_q;
    logic irq_d;
    logic trap_q;
    logic trap_d;
    rep_state_e rep_state_q;
    rep_state_e rep_state_d;
    logic [REP_CNT_W-1:0] rep_cnt_q;
    logic [REP_CNT_W-1:0] rep_cnt_d;

    logic [2*WORD_W+1:0] prod;
    logic [ACC_W-1:0] prod_ext;
    logic [ACC_W-1:0] cat_ext;
    logic [ACC_W-1:0] a_in;
    logic [ACC_W-1:0] b_in;
    logic [ACC_W:0] sum;
    logic [ACC_W-1:0] res;
    logic res_e;
    logic ovf40;
    logic carry;
    logic sat_neg;
    logic [FLG_W-1:0] rise;
    logic irq_hit;

    mac_shift_if shx ();

    mac_acc_shifter u_shifter (
        .sh(shx.shifter)
    );

    // Shifter always looks at the live accumulator
    assign shx.acc = acc_q;
    assign shx.amt = i_shift_amt;
    assign shx.mode = i_shift_mode;

    // Multiplier with per-operand sign control; a 17-bit extension covers both signednesses
    assign prod = 34'($signed({i_ma_signed & i_ma[WORD_W-1], i_ma})
        * $signed({i_mb_signed & i_mb[WORD_W-1], i_mb}));

    // Sign-extended product and bus concatenation, each with its optional one-bit scaler
    always_comb
    begin
        prod_ext = {{(ACC_W-2*WORD_W-2){prod[2*WORD_W+1]}}, prod};
        if (mcw_q[MCW_MP])
        begin
            prod_ext = prod_ext << 1;
        end
        cat_ext = {{EXT_W{i_ma[WORD_W-1]}}, i_ma, i_mb};
        if (i_concat_shift)
        begin
            cat_ext = cat_ext << 1;
        end
    end

    // Adder input selection; inverting B adds one so the adder subtracts
    always_comb
    begin
        unique case (i_a_sel)
            A_SEL_ZERO: a_in = A_ZERO;
            A_SEL_ROUND: a_in = A_ROUND;
            A_SEL_PROD: a_in = prod_ext;
            A_SEL_CONCAT: a_in = cat_ext;
        endcase
        unique case (i_b_sel)
            B_SEL_ACC: b_in = shx.res;
            B_SEL_ACC_INV: b_in = ~shx.res;
            default: b_in = A_ZERO;
        endcase
    end

    // Forty-bit add with overflow, extension and saturation decisions
    always_comb
    begin
        sum = {1'b0, a_in} + {1'b0, b_in} + {{ACC_W{1'b0}}, (i_b_sel == B_SEL_ACC_INV)};
        res = sum[ACC_W-1:0];
        carry = sum[ACC_W];
        ovf40 = (a_in[ACC_W-1] == b_in[ACC_W-1]) && (res[ACC_W-1] != a_in[ACC_W-1]);
        if (i_shift_mode == SH_LEFT)
        begin
            // A left shift reports its own lost bits and carry
            ovf40 = ovf40 || shx.ovf;
            carry = shx.carry;
        end
        // After a 40-bit wrap the true sign is the inverse of the result sign
        sat_neg = ovf40 ? !res[ACC_W-1] : res[ACC_W-1];
        res_e = !((&res[ACC_W-1:2*WORD_W-1]) || !(|res[ACC_W-1:2*WORD_W-1]));
        if (i_round)
        begin
            res[WORD_W-1:0] = '0;
        end
    end

    // Accumulator and status flags; sticky flags only OR in new events, except when a status word write replaces them
    always_comb
    begin
        acc_d = acc_q;
        flg_d = flg_q;
        if (i_msw_wr)
        begin
            flg_d = i_wdata[WORD_W-1:EXT_W];
            acc_d[ACC_W-1:2*WORD_W] = i_wdata[EXT_W-1:0];
        end
        if (i_mah_wr)
        begin
            acc_d[2*WORD_W-1:WORD_W] = i_wdata;
        end
        if (i_mal_wr)
        begin
            acc_d[WORD_W-1:0] = i_wdata;
        end
        if (i_op_valid)
        begin
            acc_d = res;
            flg_d[FLG_E] = res_e;
            if (mcw_q[MCW_MS] && (ovf40 || res_e))
            begin
                acc_d = sat_neg ? SAT_NEG : SAT_POS;
                flg_d[FLG_E] = 1'b0;
                flg_d[FLG_SL] = 1'b1;
            end
            if (ovf40)
            begin
                flg_d[FLG_SV] = 1'b1;
            end
            flg_d[FLG_N] = acc_d[ACC_W-1];
            flg_d[FLG_Z] = (acc_d == A_ZERO);
            if (i_shift_mode != SH_RIGHT)
            begin
                flg_d[FLG_C] = carry;
            end
        end
        // Interrupt pending is set on masked flags that go from clear to set
        rise = flg_d & ~flg_q;
        irq_hit = mcw_q[MCW_MIE] && ((rise[FLG_C] && mcw_q[MCW_CM])
            || (rise[FLG_SV] && mcw_q[MCW_VM])
            || (rise[FLG_E] && mcw_q[MCW_EM])
            || (rise[FLG_SL] && mcw_q[MCW_LM]));
        if (irq_hit)
        begin
            flg_d[FLG_MIR] = 1'b1;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            acc_q <= ACC_RST;
            flg_q <= FLG_RST;
        end
        else
        begin
            acc_q <= acc_d;
            flg_q <= flg_d;
        end
    end

    // Control word is plain software state
    always_comb
    begin
        mcw_d = i_mcw_wr ? i_wdata : mcw_q;
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            mcw_q <= MCW_RST;
        end
        else
        begin
            mcw_q <= mcw_d;
        end
    end

    // Limited view is computed from next state so it always matches the accumulator
    always_comb
    begin
        if (flg_d[FLG_E])
        begin
            lim_d = flg_d[FLG_N] ? LIM_NEG : LIM_POS;
        end
        else
        begin
            lim_d = acc_d[2*WORD_W-1:WORD_W];
        end
    end

    // Read-only register; nothing here feeds back into the accumulator or flags
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            lim_q <= '0;
        end
        else
        begin
            lim_q <= lim_d;
        end
    end

    // Trap request pulse and trap flag; a new request beats a same-cycle clear
    always_comb
    begin
        irq_d = irq_hit;
        trap_d = trap_q;
        if (i_trap_flag_clr)
        begin
            trap_d = 1'b0;
        end
        if (irq_hit)
        begin
            trap_d = 1'b1;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            irq_q <= 1'b0;
            trap_q <= 1'b0;
        end
        else
        begin
            irq_q <= irq_d;
            trap_q <= trap_d;
        end
    end

    // Repeat unit; an interrupt just stops exec pulses, so count and flag hold
    always_comb
    begin
        rep_state_d = rep_state_q;
        rep_cnt_d = rep_cnt_q;
        o_rep_again = 1'b0;
        if (i_mrw_wr)
        begin
            // The issuing side leaves a gap before the next repeated instruction
            rep_cnt_d = i_wdata[REP_CNT_W-1:0];
            rep_state_d = rep_state_e'(i_wdata[MRW_MR]);
        end
        if (i_rep_start)
        begin
            rep_state_d = REP_RUN;
            if (i_rep_imm_valid)
            begin
                // An immediate of zero is treated as a single execution
                rep_cnt_d = (i_rep_imm == '0) ? '0
                    : REP_CNT_W'(i_rep_imm) - REP_CNT_W'(1);
            end
        end
        else
        begin
            unique case (rep_state_q)
                REP_IDLE:
                begin
                    rep_state_d = rep_state_d;
                end
                REP_RUN:
                begin
                    if (i_rep_exec)
                    begin
                        if (rep_cnt_q == '0)
                        begin
                            rep_state_d = REP_IDLE;
                        end
                        else
                        begin
                            rep_cnt_d = rep_cnt_q - REP_CNT_W'(1);
                            o_rep_again = 1'b1;
                        end
                    end
                    else
                    begin
                        rep_cnt_d = rep_cnt_d;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            rep_state_q <= REP_IDLE;
            rep_cnt_q <= REP_CNT_RST;
        end
        else
        begin
            rep_state_q <= rep_state_d;
            rep_cnt_q <= rep_cnt_d;
        end
    end

    // Register views
    assign o_mac_status_word = {flg_q, acc_q[ACC_W-1:2*WORD_W]};
    assign o_mac_control_word = mcw_q;
    assign o_mac_repeat_word = {(rep_state_q == REP_RUN),
        {(WORD_W-REP_CNT_W-1){1'b0}}, rep_cnt_q};
    assign o_acc_high_word = acc_q[2*WORD_W-1:WORD_W];
    assign o_acc_low_word = acc_q[WORD_W-1:0];
    assign o_limited_acc_view = lim_q;
    assign o_coproc_irq = irq_q;
    assign o_coproc_trap_flag = trap_q;
    assign o_trap_number = TRAP_NUM;

endmodule // mac_accumulate_datapath

// ==== inc/mac_pkg.sv ====
package mac_pkg;

    // Datapath widths
    localparam int ACC_W = 40;
    localparam int WORD_W = 16;
    localparam int EXT_W = 8;
    localparam int SH_AMT_W = 4;
    localparam int SHIFT_MAX = 8;
    localparam int REP_CNT_W = 13;
    localparam int REP_IMM_W = 5;
    localparam int FLG_W = 8;

    // Adder A-input constants and saturation values
    localparam logic [ACC_W-1:0] A_ZERO = 40'h00_0000_0000;
    localparam logic [ACC_W-1:0] A_ROUND = 40'h00_0000_8000;
    localparam logic [ACC_W-1:0] SAT_POS = 40'h00_7fff_ffff;
    localparam logic [ACC_W-1:0] SAT_NEG = 40'hff_8000_0000;
    localparam logic [WORD_W-1:0] LIM_POS = 16'h7fff;
    localparam logic [WORD_W-1:0] LIM_NEG = 16'h8000;

    // Flag positions inside the upper byte of the status word
    localparam int FLG_N = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_C = 2;
    localparam int FLG_SL = 3;
    localparam int FLG_E = 4;
    localparam int FLG_SV = 5;
    localparam int FLG_MIR = 6;

    // Control word bit positions
    localparam int MCW_CM = 5;
    localparam int MCW_VM = 6;
    localparam int MCW_EM = 7;
    localparam int MCW_LM = 8;
    localparam int MCW_MP = 9;
    localparam int MCW_MS = 10;
    localparam int MCW_MIE = 11;

    // Repeat word layout
    localparam int MRW_MR = 15;

    // Reset values
    localparam logic [FLG_W-1:0] FLG_RST = 8'h00;
    localparam logic [WORD_W-1:0] MCW_RST = 16'h0000;
    localparam logic [ACC_W-1:0] ACC_RST = 40'h00_0000_0000;
    localparam logic [REP_CNT_W-1:0] REP_CNT_RST = 13'h0000;

    // Trap identity
    localparam logic [3:0] TRAP_NUM = 4'ha;
    localparam int TFR_TRAP_BIT = 6;

    typedef enum logic [1:0] {
        A_SEL_ZERO = 2'b00,
        A_SEL_ROUND = 2'b01,
        A_SEL_PROD = 2'b10,
        A_SEL_CONCAT = 2'b11
    } a_sel_e;

    typedef enum logic [1:0] {
        B_SEL_ZERO = 2'b00,
        B_SEL_ACC = 2'b01,
        B_SEL_ACC_INV = 2'b10
    } b_sel_e;

    typedef enum logic [1:0] {
        SH_NONE = 2'b00,
        SH_LEFT = 2'b01,
        SH_RIGHT = 2'b10
    } shift_e;

    typedef enum logic {
        REP_IDLE = 1'b0,
        REP_RUN = 1'b1
    } rep_state_e;

endpackage

// ==== inc/mac_shift_if.sv ====
`timescale 1ns/10ps
interface mac_shift_if;
    import mac_pkg::*;
    logic [ACC_W-1:0] acc;
    logic [SH_AMT_W-1:0] amt;
    shift_e mode;
    logic [ACC_W-1:0] res;
    logic carry;
    logic ovf;
    modport core (output acc, output amt, output mode, input res, input carry, input ovf);
    modport shifter (input acc, input amt, input mode, output res, output carry, output ovf);
endinterface

// ==== hdl/mac_acc_shifter.sv ====
`timescale 1ns/10ps
module mac_acc_shifter
    import mac_pkg::*;
(
    mac_shift_if.shifter sh
);

    logic [ACC_W+EXT_W-1:0] ext;
    logic [ACC_W+EXT_W-1:0] wide;
    logic [SH_AMT_W-1:0] amt;

    // Arithmetic shift; left shift works on a sign-extended copy so lost bits stay visible
    always_comb
    begin
        amt = (sh.amt > SH_AMT_W'(SHIFT_MAX)) ? SH_AMT_W'(SHIFT_MAX) : sh.amt;
        ext = {{EXT_W{sh.acc[ACC_W-1]}}, sh.acc};
        wide = ext;
        sh.res = sh.acc;
        sh.carry = 1'b0;
        sh.ovf = 1'b0;
        unique case (sh.mode)
            SH_LEFT:
            begin
                wide = ext << amt;
                sh.res = wide[ACC_W-1:0];
                // Carry is the last bit pushed past the top
                sh.carry = (amt != '0) ? wide[ACC_W] : 1'b0;
                sh.ovf = !((&wide[ACC_W+EXT_W-1:ACC_W-1]) || !(|wide[ACC_W+EXT_W-1:ACC_W-1]));
            end
            SH_RIGHT:
            begin
                sh.res = $signed(sh.acc) >>> amt;
            end
            default:
            begin
                sh.res = sh.acc;
            end
        endcase
    end

endmodule // mac_acc_shifter

// ==== verif/mac_accumulate_datapath_sva.sv ====
`timescale 1ns/10ps
module mac_accumulate_datapath_sva
    import mac_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_op_valid,
    input wire logic i_msw_wr,
    input wire logic i_mah_wr,
    input wire logic i_mal_wr,
    input wire logic i_mrw_wr,
    input wire logic i_rep_start,
    input wire logic i_rep_imm_valid,
    input wire logic [REP_IMM_W-1:0] i_rep_imm,
    input wire logic i_rep_exec,
    input wire logic o_rep_again,
    input wire logic [WORD_W-1:0] o_mac_status_word,
    input wire logic [WORD_W-1:0] o_mac_control_word,
    input wire logic [WORD_W-1:0] o_mac_repeat_word,
    input wire logic [WORD_W-1:0] o_acc_high_word,
    input wire logic [WORD_W-1:0] o_acc_low_word,
    input wire logic [WORD_W-1:0] o_limited_acc_view,
    input wire logic o_coproc_irq,
    input wire logic o_coproc_trap_flag
);
    logic sv, sl, e_f, quiet, run, step;
    logic [REP_CNT_W-1:0] cnt;
    logic [ACC_W-1:0] acc;

    // Named views; quiet excludes software writes that would mask the datapath result
    assign sv = o_mac_status_word[8+FLG_SV];
    assign sl = o_mac_status_word[8+FLG_SL];
    assign e_f = o_mac_status_word[8+FLG_E];
    assign quiet = !(i_msw_wr || i_mah_wr || i_mal_wr);
    assign run = o_mac_repeat_word[MRW_MR];
    assign cnt = o_mac_repeat_word[REP_CNT_W-1:0];
    assign acc = {o_mac_status_word[7:0], o_acc_high_word, o_acc_low_word};
    assign step = run && i_rep_exec && !i_rep_start && !i_mrw_wr;

    default clocking cb_main @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);

    // Datapath flags and read-out
    property p_irq; o_coproc_irq |-> o_coproc_trap_flag && o_mac_status_word[8+FLG_MIR]; endproperty
    a_irq: assert property (p_irq) else $error("irq without pending flags");
    property p_sv; sv && !i_msw_wr |=> sv; endproperty
    a_sv: assert property (p_sv) else $error("overflow flag dropped");
    property p_sl; sl && !i_msw_wr |=> sl; endproperty
    a_sl: assert property (p_sl) else $error("limit flag dropped");
    property p_ext;
        i_op_valid && quiet && !o_mac_control_word[MCW_MS]
            |=> e_f == (o_mac_status_word[7:0] != {8{o_acc_high_word[15]}});
    endproperty
    a_ext: assert property (p_ext) else $error("extension flag wrong");
    property p_sat; i_op_valid && quiet && o_mac_control_word[MCW_MS] |=> !e_f; endproperty
    a_sat: assert property (p_sat) else $error("no saturation");
    property p_lim;
        o_limited_acc_view == (e_f ? (o_mac_status_word[8+FLG_N] ? LIM_NEG : LIM_POS)
            : o_acc_high_word);
    endproperty
    a_lim: assert property (p_lim) else $error("limited view wrong");
    property p_hold; !i_op_valid && quiet |=> $stable(acc); endproperty
    a_hold: assert property (p_hold) else $error("acc changed idle");

    // Repeat unit
    property p_imm;
        i_rep_start && i_rep_imm_valid && i_rep_imm != 5'h00
            |=> run && cnt == 13'($past(i_rep_imm)) - 13'h0001;
    endproperty
    a_imm: assert property (p_imm) else $error("immediate count wrong");
    property p_last; step && cnt == 13'h0000 |-> !o_rep_again ##1 !run; endproperty
    a_last: assert property (p_last) else $error("repeat did not end");
    property p_dec;
        step && cnt != 13'h0000 |-> o_rep_again ##1 (run && cnt == $past(cnt) - 13'h0001);
    endproperty
    a_dec: assert property (p_dec) else $error("repeat count step wrong");
    property p_susp; run && !i_rep_exec && !i_rep_start && !i_mrw_wr |=> $stable(cnt) && run;
    endproperty
    a_susp: assert property (p_susp) else $error("suspended repeat moved");

    c_irq: cover property (o_coproc_irq);
    c_sat: cover property ($rose(sl));
    c_last: cover property (step && cnt == 13'h0000);
endmodule // mac_accumulate_datapath_sva

bind mac_accumulate_datapath mac_accumulate_datapath_sva sva_u (.*);

// ==== verif/mac_host_model.sv ====
`timescale 1ns/10ps
module mac_host_model (
    input wire logic i_mclk,
    input wire logic i_go,
    input wire logic i_slow,
    input wire logic i_rep_again,
    output logic o_exec,
    output int o_runs,
    output logic o_busy
);
    int stall;

    // Pipeline issuing repeated executions; random stalls stand in for interrupts
    initial
    begin
        o_exec = 1'h0;
        o_busy = 1'h0;
        o_runs = 0;
        forever
        begin
            @(posedge i_mclk);
            if (i_go)
            begin
                o_busy = 1'h1;
                o_runs = 0;
                while (o_busy)
                begin
                    #1;
                    stall = i_slow ? $urandom_range(3, 0) : 0;
                    if (stall > 0)
                    begin
                        o_exec = 1'h0;
                        repeat (stall) @(posedge i_mclk);
                        #1;
                    end
                    o_exec = 1'h1;
                    @(posedge i_mclk);
                    o_runs++;
                    o_busy = i_rep_again; // Stop when no further execution is due
                end
                #1;
                o_exec = 1'h0;
            end
        end
    end
endmodule // mac_host_model

// ==== verif/mac_accumulate_datapath_tb_top.sv ====
`timescale 1ns/10ps
module mac_accumulate_datapath_tb_top;
    import mac_pkg::*;
    logic i_mclk, i_rst_n, i_op_valid, i_concat_shift, i_round, i_ma_signed, i_mb_signed;
    logic i_msw_wr, i_mcw_wr, i_mrw_wr, i_mah_wr, i_mal_wr, i_rep_start, i_rep_imm_valid;
    logic i_rep_exec, i_trap_flag_clr, o_rep_again, o_coproc_irq, o_coproc_trap_flag;
    a_sel_e i_a_sel;
    b_sel_e i_b_sel;
    shift_e i_shift_mode;
    logic [SH_AMT_W-1:0] i_shift_amt;
    logic [REP_IMM_W-1:0] i_rep_imm;
    logic [WORD_W-1:0] i_ma, i_mb, i_wdata, o_mac_status_word, o_mac_control_word;
    logic [WORD_W-1:0] o_mac_repeat_word, o_acc_high_word, o_acc_low_word, o_limited_acc_view;
    logic [3:0] o_trap_number;
    logic slow, busy, cs;
    int runs, n_errors, check_count, k;
    logic [ACC_W-1:0] ex;
    logic [WORD_W-1:0] ma, mb;
    logic [31:0] seed;

    mac_accumulate_datapath dut_u (.*);
    mac_host_model host_u (.i_mclk(i_mclk), .i_go(i_rep_start), .i_slow(slow),
        .i_rep_again(o_rep_again), .o_exec(i_rep_exec), .o_runs(runs), .o_busy(busy));

    initial
    begin
        i_mclk = 1'h0;
        forever #25 i_mclk = ~i_mclk;
    end

    function automatic logic [ACC_W-1:0] sx(input logic [31:0] v);
        return {{8{v[31]}}, v};
    endfunction
    function automatic logic e_of(input logic [ACC_W-1:0] v);
        return (v[39:31] != 9'h000) && (v[39:31] != 9'h1ff);
    endfunction

    task automatic tick();
        @(posedge i_mclk);
        #1;
    endtask
    task automatic chk(input string s, input logic [ACC_W-1:0] got, input logic [ACC_W-1:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", s, exp, got);
        end
    endtask
    task automatic chk_acc(input logic [ACC_W-1:0] e);
        chk("acc", {o_mac_status_word[7:0], o_acc_high_word, o_acc_low_word}, e);
        chk("ext flag", o_mac_status_word[8+FLG_E], e_of(e));
        chk("view", o_limited_acc_view, e_of(e) ? (e[39] ? LIM_NEG : LIM_POS) : e[31:16]);
    endtask
    // Software write: 0 status, 1 control, 2 repeat, 3 acc high, 4 acc low, 5 idle cycle
    task automatic wr(input int s, input logic [WORD_W-1:0] d);
        i_op_valid = 1'h0;
        i_wdata = d;
        {i_mal_wr, i_mah_wr, i_mrw_wr, i_mcw_wr, i_msw_wr} = 5'h01 << s;
        tick();
    endtask
    task automatic op(input a_sel_e a, input b_sel_e b, input shift_e s, input logic [3:0] n,
                      input logic [15:0] x, input logic [15:0] y, input logic c, input logic r);
        {i_mal_wr, i_mah_wr, i_mrw_wr, i_mcw_wr, i_msw_wr} = 5'h00;
        i_a_sel = a;
        i_b_sel = b;
        i_shift_mode = s;
        i_shift_amt = n;
        i_ma = x;
        i_mb = y;
        i_concat_shift = c;
        i_round = r;
        i_op_valid = 1'h1;
        tick();
    endtask
    task automatic ld(input logic [15:0] x, input logic [15:0] y);
        op(A_SEL_CONCAT, B_SEL_ZERO, SH_NONE, 4'h0, x, y, 1'h0, 1'h0);
    endtask
    task automatic sh(input shift_e s, input logic [3:0] n);
        op(A_SEL_ZERO, B_SEL_ACC, s, n, 16'h0000, 16'h0000, 1'h0, 1'h0);
    endtask
    task automatic rep(input logic iv, input logic [4:0] imm, input int n);
        wr(5, 16'h0000);
        i_rep_imm_valid = iv;
        i_rep_imm = imm;
        i_rep_start = 1'h1;
        tick();
        i_rep_start = 1'h0;
        chk("repeat word", o_mac_repeat_word, {3'h4, 13'(n)});
        for (int j = 0; j < 30000 && busy; j++) tick();
        chk("executions", runs, n + 1);
        tick();
        chk("repeat active", o_mac_repeat_word[MRW_MR], 1'h0);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Watchdog sized well above the longest repeat run
    initial
    begin
        repeat (40000) @(posedge i_mclk);
        n_errors++;
        $display("[FAIL] watchdog expected finish seen timeout");
        end_sim();
    end

    initial
    begin
        seed = $urandom(32'hd5af);
        {i_rst_n, i_op_valid, i_concat_shift, i_round, i_msw_wr, i_mcw_wr, i_mrw_wr} = 7'h00;
        {i_mah_wr, i_mal_wr, i_rep_start, i_rep_imm_valid, i_trap_flag_clr, slow} = 6'h00;
        {i_ma_signed, i_mb_signed, i_shift_amt, i_rep_imm, i_ma, i_mb, i_wdata} = 59'h3 << 57;
        i_a_sel = A_SEL_ZERO;
        i_b_sel = B_SEL_ZERO;
        i_shift_mode = SH_NONE;
        n_errors = 0;
        check_count = 0;
        repeat (4) @(posedge i_mclk);
        #1;
        i_rst_n = 1'h1;
        chk("reset status", o_mac_status_word, 16'h0000);
        chk("trap number", o_trap_number, TRAP_NUM);
        wr(0, 16'h00ff);
        wr(3, 16'h8000);
        wr(4, 16'h0001);
        chk_acc(40'hff_8000_0001);
        // Random loads, accumulations and reverse subtractions
        for (int i = 0; i < 8; i++)
        begin
            {ma, mb, cs} = {16'($urandom), 16'($urandom), 1'($urandom)};
            op(A_SEL_CONCAT, B_SEL_ZERO, SH_NONE, 4'h0, ma, mb, cs, 1'h0);
            ex = sx({ma, mb}) << cs;
            chk_acc(ex);
            {ma, mb} = {16'($urandom), 16'($urandom)};
            op(A_SEL_CONCAT, B_SEL_ACC, SH_NONE, 4'h0, ma, mb, 1'h0, 1'h0);
            ex = ex + sx({ma, mb});
            chk_acc(ex);
            op(A_SEL_CONCAT, B_SEL_ACC_INV, SH_NONE, 4'h0, ma, mb, 1'h0, 1'h0);
            ex = sx({ma, mb}) - ex;
            chk_acc(ex);
        end
        ld(16'h7fff, 16'hffff);
        sh(SH_LEFT, 4'h8);
        chk_acc(40'h7f_ffff_ff00);
        sh(SH_LEFT, 4'h8);
        chk_acc(40'hff_ffff_0000);
        chk("overflow flag", o_mac_status_word[8+FLG_SV], 1'h1);
        ld(16'h8000, 16'h0000);
        sh(SH_RIGHT, 4'h4);
        chk_acc(40'hff_f800_0000);
        chk("overflow sticky", o_mac_status_word[8+FLG_SV], 1'h1);
        // Saturation on, both directions and on a left shift
        wr(0, 16'h0000);
        wr(1, 16'h0400);
        ld(16'h7fff, 16'hffff);
        op(A_SEL_CONCAT, B_SEL_ACC, SH_NONE, 4'h0, 16'h0000, 16'h0001, 1'h0, 1'h0);
        chk_acc(SAT_POS);
        ld(16'h8000, 16'h0000);
        op(A_SEL_CONCAT, B_SEL_ACC, SH_NONE, 4'h0, 16'hffff, 16'hffff, 1'h0, 1'h0);
        chk_acc(SAT_NEG);
        ld(16'h0100, 16'h0000);
        sh(SH_LEFT, 4'h8);
        chk_acc(SAT_POS);
        ld(16'h1234, 16'h8000);
        op(A_SEL_ROUND, B_SEL_ACC, SH_NONE, 4'h0, 16'h0000, 16'h0000, 1'h0, 1'h1);
        chk_acc(40'h00_1235_0000);
        chk("limit sticky", o_mac_status_word[8+FLG_SL], 1'h1);
        // Fractional products, the corner of two most negative operands first
        wr(1, 16'h0200);
        for (int i = 0; i < 6; i++)
        begin
            ma = (i == 0) ? 16'h8000 : 16'($urandom);
            mb = (i == 0) ? 16'h8000 : 16'($urandom);
            op(A_SEL_PROD, B_SEL_ZERO, SH_NONE, 4'h0, ma, mb, 1'h0, 1'h0);
            ex = sx($signed(ma) * $signed(mb)) << 1;
            chk_acc(ex);
        end
        // Interrupt on a masked extension flag, then the handler clears it
        wr(0, 16'h0000);
        wr(1, 16'h0880);
        chk("control", o_mac_control_word, 16'h0880);
        op(A_SEL_CONCAT, B_SEL_ZERO, SH_NONE, 4'h0, 16'h7fff, 16'hffff, 1'h1, 1'h0);
        for (k = 0; k < 3 && o_coproc_irq !== 1'h1; k++) tick();
        chk("irq", o_coproc_irq, 1'h1);
        chk("trap flag", o_coproc_trap_flag, 1'h1);
        chk("irq pending", o_mac_status_word[8+FLG_MIR], 1'h1);
        i_trap_flag_clr = 1'h1;
        wr(5, 16'h0000);
        i_trap_flag_clr = 1'h0;
        wr(0, 16'h0000);
        chk("trap cleared", {o_coproc_trap_flag, o_mac_status_word[8+FLG_MIR]}, 2'h0);
        wr(1, 16'h0800);
        op(A_SEL_CONCAT, B_SEL_ZERO, SH_NONE, 4'h0, 16'h7fff, 16'hffff, 1'h1, 1'h0);
        chk("masked irq", {o_coproc_irq, o_mac_status_word[8+FLG_MIR]}, 2'h0);
        // Repeat unit with a stalling pipeline, then a full 8191 count without stalls
        wr(1, 16'h0000);
        slow = 1'h1;
        for (int i = 0; i < 3; i++)
        begin
            k = (i == 0) ? 31 : $urandom_range(30, 1);
            rep(1'h1, 5'(k), k - 1);
        end
        k = $urandom_range(40, 0);
        wr(2, 16'(k));
        wr(5, 16'h0000);
        rep(1'h0, 5'h00, k);
        slow = 1'h0;
        wr(2, 16'h1fff);
        wr(5, 16'h0000);
        rep(1'h0, 5'h00, 8191);
        end_sim();
    end
endmodule // mac_accumulate_datapath_tb_top
